// ==== design/sbx_alu.sv ====
`timescale 1ns/1ps
module sbx_alu
  import sbx_pkg::*;
(
  sbx_alu_if.alu a
);
  logic [8:0] full;
  logic [4:0] nib;

  // Two's complement: add the inverted subtrahend plus one; carry out is inverted borrow
  always_comb
  begin
    full = {1'b0, a.minuend} + {1'b0, ~a.subtrahend} + 9'h001; // RQ3 RQ9
    nib = {1'b0, a.minuend[3:0]} + {1'b0, ~a.subtrahend[3:0]} + 5'h01;
    a.diff = full[7:0];
    a.no_borrow = full[8]; // RQ7 RQ8 RQ9
    a.nib_no_borrow = nib[4]; // RQ12
    a.zero = (full[7:0] == 8'h00); // RQ8
  end
endmodule // sbx_alu

// ==== design/sbx_alu_if.sv ====
`timescale 1ns/1ps
interface sbx_alu_if;
  logic [7:0] minuend;
  logic [7:0] subtrahend;
  logic [7:0] diff;
  logic no_borrow;
  logic nib_no_borrow;
  logic zero;

  modport core (output minuend, output subtrahend,
                input diff, input no_borrow, input nib_no_borrow, input zero);
  modport alu (input minuend, input subtrahend,
               output diff, output no_borrow, output nib_no_borrow, output zero);
endinterface

// ==== design/sbx_core.sv ====
// Decided for this implementation: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "sbx_defs.svh"
// Function
// (RQ1) Power-down: decode in Q1, idle Q2 and Q3, enter low power in Q4.
// (RQ2) Power-down clears watchdog and prescaler, sets timeout bit, clears powerdown bit.
// (RQ3) Immediate subtract: literal minus working register, result into working register.
// (RQ4) Immediate subtract decoded from upper bits 11 110x, low byte is literal.
// (RQ5) Immediate subtract updates carry, digit carry, zero only.
// (RQ6) Immediate subtract: decode Q1, read Q2, compute Q3, write Q4.
// (RQ7) Minuend above subtrahend: carry set, zero cleared.
// (RQ8) Equal operands: carry set, zero set.
// (RQ9) Subtrahend above minuend: carry and zero cleared, wrapped 8-bit result.
// (RQ10) Destination bit 0 writes working register, 1 writes the file register.
// (RQ11) File subtract: file minus working register, read Q2, write Q4, flags updated.
// (RQ12) Digit carry set when the low nibble does not borrow.
module sbx_core
  import sbx_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic sleep_o
);

  sbx_state_t r;
  sbx_state_t next_r;
  sbx_alu_if alu_if();
  logic busy;
  logic [31:0] rd;
  logic [31:0] wv;
  logic [7:0] status;

  sbx_alu u_alu (
    .a(alu_if)
  );

  assign alu_if.minuend = r.opa;
  assign alu_if.subtrahend = r.opb;
  assign busy = (r.ph != PH_IDLE);

  always_comb
  begin
    status = 8'h00;
    status[`SBX_ST_CARRY] = r.c;
    status[`SBX_ST_DCARRY] = r.dc;
    status[`SBX_ST_ZERO] = r.z;
    status[`SBX_ST_PD] = r.pd;
    status[`SBX_ST_TO] = r.to;
    status[`SBX_ST_ASLEEP] = r.asleep;
    status[`SBX_ST_BUSY] = busy;
  end

  always_comb
  begin
    next_r = r;
    rd = 32'h0000_0000;
    wv = 32'h0000_0000;
    // Classic single-cycle answer; ack drops in the cycle after it was given
    next_r.ack = wb_cyc_i && wb_stb_i && !r.ack;

    // Watchdog runs only while awake
    if (!r.asleep)
    begin
      next_r.pre = r.pre + 8'h01;
      if (r.pre == `SBX_PRE_MAX)
      begin
        next_r.wdog = r.wdog + 8'h01;
      end
    end

    case (r.ph)
      PH_IDLE:
      begin
        next_r.ph = PH_IDLE;
      end
      PH_Q1:
      begin
        next_r.op = sbx_decode(r.instr); // RQ4 RQ1
        next_r.ph = PH_Q2;
      end
      PH_Q2:
      begin
        // Power-down does nothing here
        if (r.op == OP_SUBL)
        begin
          next_r.opa = r.instr[7:0]; // RQ3 RQ6
          next_r.opb = r.w;
        end
        else if (r.op == OP_SUBF)
        begin
          next_r.opa = r.fregs[r.instr[6:0]]; // RQ11
          next_r.opb = r.w;
        end
        next_r.ph = PH_Q3;
      end
      PH_Q3:
      begin
        next_r.res = alu_if.diff; // RQ6 RQ11
        next_r.ph = PH_Q4;
      end
      PH_Q4:
      begin
        case (r.op)
          OP_SUBL:
          begin
            next_r.w = r.res; // RQ3 RQ6
            next_r.c = alu_if.no_borrow; // RQ5 RQ7 RQ8 RQ9
            next_r.dc = alu_if.nib_no_borrow; // RQ12
            next_r.z = alu_if.zero; // RQ5
          end
          OP_SUBF:
          begin
            if (r.instr[7])
            begin
              next_r.fregs[r.instr[6:0]] = r.res; // RQ10 RQ11
            end
            else
            begin
              next_r.w = r.res; // RQ10
            end
            next_r.c = alu_if.no_borrow; // RQ11 RQ7 RQ8 RQ9
            next_r.dc = alu_if.nib_no_borrow; // RQ12
            next_r.z = alu_if.zero; // RQ11
          end
          OP_SLEEP:
          begin
            next_r.asleep = 1'b1; // RQ1
            next_r.wdog = `SBX_WDOG_CLR; // RQ2
            next_r.pre = `SBX_WDOG_CLR; // RQ2
            next_r.to = 1'b1; // RQ2
            next_r.pd = 1'b0; // RQ2
          end
          default:
          begin
            next_r.op = OP_NONE;
          end
        endcase
        next_r.ph = PH_IDLE;
      end
      default:
      begin
        next_r.ph = PH_IDLE;
      end
    endcase

    // Bus access; writes other than to the file address are refused mid-instruction so the core never races software
    if (wb_cyc_i && wb_stb_i && !r.ack)
    begin
      case (wb_adr_i)
        `SBX_ADR_INSTR:
        begin
          rd = {18'h0_0000, r.instr};
          wv = sbx_wmerge(rd, wb_dat_i, wb_sel_i);
          if (wb_we_i && !busy && !r.asleep)
          begin
            next_r.instr = wv[13:0];
            next_r.ph = PH_Q1;
          end
        end
        `SBX_ADR_WREG:
        begin
          rd = {24'h00_0000, r.w};
          wv = sbx_wmerge(rd, wb_dat_i, wb_sel_i);
          if (wb_we_i && !busy)
          begin
            next_r.w = wv[7:0];
          end
        end
        `SBX_ADR_STATUS:
        begin
          rd = {24'h00_0000, status};
          wv = sbx_wmerge(rd, wb_dat_i, wb_sel_i);
          if (wb_we_i && !busy)
          begin
            next_r.c = wv[`SBX_ST_CARRY];
            next_r.dc = wv[`SBX_ST_DCARRY];
            next_r.z = wv[`SBX_ST_ZERO];
            next_r.pd = wv[`SBX_ST_PD];
            next_r.to = wv[`SBX_ST_TO];
            // Only a wake is possible here; sleep is entered by the instruction alone
            next_r.asleep = r.asleep && wv[`SBX_ST_ASLEEP];
          end
        end
        `SBX_ADR_FADDR:
        begin
          rd = {25'h000_0000, r.faddr};
          wv = sbx_wmerge(rd, wb_dat_i, wb_sel_i);
          if (wb_we_i)
          begin
            next_r.faddr = wv[6:0];
          end
        end
        `SBX_ADR_FDATA:
        begin
          rd = {24'h00_0000, r.fregs[r.faddr]};
          wv = sbx_wmerge(rd, wb_dat_i, wb_sel_i);
          if (wb_we_i && !busy)
          begin
            next_r.fregs[r.faddr] = wv[7:0];
          end
        end
        `SBX_ADR_WDOG:
        begin
          rd = {16'h0000, r.pre, r.wdog};
        end
        default:
        begin
          rd = 32'h0000_0000;
        end
      endcase
      next_r.dat = rd;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      r <= '0;
      r.to <= `SBX_TO_RST;
      r.pd <= `SBX_PD_RST;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign wb_dat_o = r.dat;
  assign wb_ack_o = r.ack;
  assign sleep_o = r.asleep;

  AST_SLEEP_AT_Q4: assert property (@(posedge clk_i) disable iff (rst_i) // RQ1
    $rose(r.asleep) |-> $past(r.ph) == PH_Q4 && $past(r.op) == OP_SLEEP)
    else $error("Low power entered outside Q4 of power-down");

  AST_SLEEP_SEQ: assert property (@(posedge clk_i) disable iff (rst_i) // RQ1
    (r.ph == PH_Q1 && sbx_decode(r.instr) == OP_SLEEP)
      |=> !r.asleep ##1 !r.asleep ##1 !r.asleep ##1 r.asleep)
    else $error("Power-down did not sleep exactly after Q4");

  AST_SLEEP_EFFECTS: assert property (@(posedge clk_i) disable iff (rst_i) // RQ2
    (r.ph == PH_Q4 && r.op == OP_SLEEP)
      |=> r.wdog == 8'h00 && r.pre == 8'h00 && r.to && !r.pd)
    else $error("Power-down side effects wrong");

  AST_SUBL_RESULT: assert property (@(posedge clk_i) disable iff (rst_i) // RQ3
    (r.ph == PH_Q2 && r.op == OP_SUBL)
      |-> ##3 r.w == 8'(r.instr[7:0] - $past(r.w, 3)))
    else $error("Immediate subtract result wrong");

  AST_SUBL_DECODE: assert property (@(posedge clk_i) disable iff (rst_i) // RQ4
    (r.ph == PH_Q2) |-> ((r.op == OP_SUBL) == (r.instr[13:9] == 5'h1E)))
    else $error("Immediate subtract decode wrong");

  AST_SUBL_NO_OTHER: assert property (@(posedge clk_i) disable iff (rst_i) // RQ5
    (r.ph == PH_Q4 && r.op == OP_SUBL && !r.ack)
      |=> r.to == $past(r.to) && r.pd == $past(r.pd) && !r.asleep)
    else $error("Immediate subtract touched other status bits");

  AST_PHASE_ORDER: assert property (@(posedge clk_i) disable iff (rst_i) // RQ6
    (r.ph == PH_Q1) |=> r.ph == PH_Q2 ##1 r.ph == PH_Q3 ##1 r.ph == PH_Q4 ##1 !busy)
    else $error("Quarter-cycle order broken");

  AST_GREATER: assert property (@(posedge clk_i) disable iff (rst_i) // RQ7
    (r.ph == PH_Q4 && r.op inside {OP_SUBL, OP_SUBF} && r.opa > r.opb) |=> r.c && !r.z)
    else $error("Greater minuend flags wrong");

  AST_EQUAL: assert property (@(posedge clk_i) disable iff (rst_i) // RQ8
    (r.ph == PH_Q4 && r.op inside {OP_SUBL, OP_SUBF} && r.opa == r.opb) |=> r.c && r.z)
    else $error("Equal operand flags wrong");

  AST_LESS: assert property (@(posedge clk_i) disable iff (rst_i) // RQ9
    (r.ph == PH_Q4 && r.op inside {OP_SUBL, OP_SUBF} && r.opa < r.opb)
      |=> !r.c && !r.z && r.res == 8'(r.opa - r.opb) + 8'h00)
    else $error("Borrow case wrong");

  AST_DEST_FILE: assert property (@(posedge clk_i) disable iff (rst_i) // RQ10
    (r.ph == PH_Q4 && r.op == OP_SUBF && r.instr[7])
      |=> r.fregs[$past(r.instr[6:0])] == $past(r.res) && r.w == $past(r.w))
    else $error("File destination not written");

  AST_SUBF_READ: assert property (@(posedge clk_i) disable iff (rst_i) // RQ11
    (r.ph == PH_Q3 && r.op == OP_SUBF) |-> r.opa == r.fregs[r.instr[6:0]] && r.opb == r.w)
    else $error("File subtract operands wrong");

  AST_DIGIT: assert property (@(posedge clk_i) disable iff (rst_i) // RQ12
    (r.ph == PH_Q4 && r.op inside {OP_SUBL, OP_SUBF})
      |=> r.dc == ($past(r.opa[3:0]) >= $past(r.opb[3:0])))
    else $error("Digit carry wrong");

endmodule // sbx_core

// ==== design/sbx_defs.svh ====
`ifndef SBX_DEFS_SVH
`define SBX_DEFS_SVH

// Register byte offsets on the bus
`define SBX_ADR_INSTR 8'h00
`define SBX_ADR_WREG 8'h04
`define SBX_ADR_STATUS 8'h08
`define SBX_ADR_FADDR 8'h0C
`define SBX_ADR_FDATA 8'h10
`define SBX_ADR_WDOG 8'h14

// Status field positions
`define SBX_ST_CARRY 0
`define SBX_ST_DCARRY 1
`define SBX_ST_ZERO 2
`define SBX_ST_PD 3
`define SBX_ST_TO 4
`define SBX_ST_ASLEEP 5
`define SBX_ST_BUSY 6

// Opcode patterns
`define SBX_SUBL_HI 5'h1E
`define SBX_SUBF_HI 6'h02
`define SBX_SLEEP_CODE 14'h0063

// Reset values, watchdog clear value and prescaler maximum
`define SBX_TO_RST 1'b1
`define SBX_PD_RST 1'b1
`define SBX_WDOG_CLR 8'h00
`define SBX_PRE_MAX 8'hFF

`endif

// ==== design/sbx_pkg.sv ====
package sbx_pkg;

  `include "sbx_defs.svh"

  typedef enum logic [2:0] {PH_IDLE, PH_Q1, PH_Q2, PH_Q3, PH_Q4} sbx_phase_t;
  typedef enum logic [1:0] {OP_NONE, OP_SUBL, OP_SUBF, OP_SLEEP} sbx_op_t;

  typedef struct packed {
    sbx_phase_t ph;
    sbx_op_t op;
    logic [13:0] instr;
    logic [7:0] w;
    logic [7:0] opa;
    logic [7:0] opb;
    logic [7:0] res;
    logic c;
    logic dc;
    logic z;
    logic pd;
    logic to;
    logic asleep;
    logic [6:0] faddr;
    logic [7:0] wdog;
    logic [7:0] pre;
    logic ack;
    logic [31:0] dat;
    logic [127:0][7:0] fregs;
  } sbx_state_t;

  function automatic sbx_op_t sbx_decode(input logic [13:0] ins);
    if (ins[13:9] == `SBX_SUBL_HI)
    begin
      return OP_SUBL;
    end
    else if (ins[13:8] == `SBX_SUBF_HI)
    begin
      return OP_SUBF;
    end
    else if (ins == `SBX_SLEEP_CODE)
    begin
      return OP_SLEEP;
    end
    return OP_NONE;
  endfunction

  function automatic logic [31:0] sbx_wmerge(input logic [31:0] old,
                                            input logic [31:0] dat,
                                            input logic [3:0] sel);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        m[i*8 +: 8] = dat[i*8 +: 8];
      end
    end
    return m;
  endfunction

endpackage

// ==== verif/sbx_wb_host.sv ====
`timescale 1ns/1ps
module sbx_wb_host (
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [31:0] rdat_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [7:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o
);
  int misses = 0;

  initial
  begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 8'h00;
    sel_o = 4'h0;
    dat_o = 32'h0000_0000;
  end

  // Ack is sampled right after the edge, before the slave's own updates land
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    sel_o <= 4'hf;
    dat_o <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_i !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      misses++;
    end
    q = rdat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o <= 1'b0;
    // Released lines show junk so a stale value never passes for a live one
    adr_o <= ~a;
    dat_o <= ~d;
  endtask
endmodule // sbx_wb_host

// ==== verif/testbench.sv ====
`timescale 1ns/1ps
`include "sbx_defs.svh"
module testbench;
  typedef struct packed {
    logic [13:0] ins;
    logic [7:0] w;
    logic [7:0] f;
    logic [7:0] ew;
    logic [7:0] ef;
    logic [2:0] fl;
  } sbx_row_t;

  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc, stb, we, ack, sleep_o;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q;
  int errors = 0;
  int tests_run = 0;
  sbx_row_t rows [9];

  always #25 clk_i = ~clk_i;

  sbx_core uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .sleep_o(sleep_o));

  sbx_wb_host host (.clk_i(clk_i), .ack_i(ack), .rdat_i(rdat), .cyc_o(cyc),
    .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    if (errors == 0 && tests_run > 0)
    begin
      $display("Testbench passed");
    end
    else
    begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    host.xfer(1'b1, a, d, dummy);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    host.xfer(1'b0, a, 32'h0000_0000, d);
  endtask

  // Polling the busy bit keeps the bench independent of the exact latency
  task automatic run(input logic [13:0] ins);
    logic [31:0] s;
    int n;
    wr(`SBX_ADR_INSTR, {18'h0, ins});
    n = 0;
    do
    begin
      rd(`SBX_ADR_STATUS, s);
      n++;
    end
    while (s[6] !== 1'b0 && n < 10);
    check({31'h0, s[`SBX_ST_BUSY]}, 32'h0000_0000);
  endtask

  initial
  begin
    repeat (20000) @(posedge clk_i);
    errors++;
    wrap_up();
  end

  initial
  begin
    rows = '{'{14'h3c02, 8'h01, 8'h00, 8'h01, 8'h00, 3'b011},
             '{14'h3c02, 8'h02, 8'h00, 8'h00, 8'h00, 3'b111},
             '{14'h3c02, 8'h03, 8'h00, 8'hff, 8'h00, 3'b000},
             '{14'h3d10, 8'h01, 8'h00, 8'h0f, 8'h00, 3'b001},
             '{14'h3c01, 8'h10, 8'h00, 8'hf1, 8'h00, 3'b010},
             '{14'h0285, 8'h02, 8'h03, 8'h02, 8'h01, 3'b011},
             '{14'h0205, 8'h02, 8'h02, 8'h00, 8'h02, 3'b111},
             '{14'h02ff, 8'h02, 8'h01, 8'h02, 8'hff, 3'b000},
             '{14'h0205, 8'h11, 8'h20, 8'h0f, 8'h20, 3'b001}};
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    check({31'h0, sleep_o}, 32'h0000_0000);
    rd(`SBX_ADR_STATUS, q);
    check(q, 32'h0000_0018);
    rd(8'h40, q);
    check(q, 32'h0000_0000);
    foreach (rows[i])
    begin
      wr(`SBX_ADR_FADDR, {25'h0, rows[i].ins[6:0]});
      wr(`SBX_ADR_FDATA, {24'h0, rows[i].f});
      wr(`SBX_ADR_WREG, {24'h0, rows[i].w});
      run(rows[i].ins);
      rd(`SBX_ADR_WREG, q);
      check(q, {24'h0, rows[i].ew});
      rd(`SBX_ADR_FDATA, q);
      check(q, {24'h0, rows[i].ef});
      rd(`SBX_ADR_STATUS, q);
      check(q, {29'h0000_0003, rows[i].fl});
    end
    // A working register write during execution must lose to the result
    wr(`SBX_ADR_WREG, 32'h0000_0003);
    wr(`SBX_ADR_INSTR, 32'h0000_3c05);
    wr(`SBX_ADR_WREG, 32'h0000_0077);
    run(14'h3fff);
    rd(`SBX_ADR_WREG, q);
    check(q, 32'h0000_0002);
    // Clear the timeout bit first so that power-down has to set it again
    wr(`SBX_ADR_STATUS, 32'h0000_0008);
    run(14'h0063);
    check({31'h0, sleep_o}, 32'h0000_0001);
    rd(`SBX_ADR_STATUS, q);
    check(q, 32'h0000_0030);
    rd(`SBX_ADR_WDOG, q);
    check(q, 32'h0000_0000);
    wr(`SBX_ADR_INSTR, 32'h0000_3c00);
    rd(`SBX_ADR_WREG, q);
    check(q, 32'h0000_0002);
    wr(`SBX_ADR_STATUS, 32'h0000_0018);
    repeat (2) @(posedge clk_i);
    check({31'h0, sleep_o}, 32'h0000_0000);
    check(32'(host.misses), 32'h0000_0000);
    wrap_up();
  end
endmodule // testbench
